/* File: shared/dtc_cfg.svh */
// Register indices, field positions, reset values and counts of the
// dual timer/counter pair.
// Assumes inclusion by bare name from a package or module; definitions only.
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// ==========================================================================
// Register indices (the byte address on the bus is four times the index)
// ==========================================================================
`define DTC_IDX_TIMER_CONFIGURATION  8'h88
`define DTC_IDX_TIMER_MODE_SELECT    8'h89
`define DTC_IDX_COUNT_LOW_ZERO       8'h8A
`define DTC_IDX_COUNT_LOW_ONE        8'h8B
`define DTC_IDX_COUNT_HIGH_ZERO      8'h8C
`define DTC_IDX_COUNT_HIGH_ONE       8'h8D
`define DTC_IDX_TIMER_CLOCK_CONTROL  8'h8E

// ==========================================================================
// Reset values
// ==========================================================================
`define DTC_RST_TIMER_CONFIGURATION  8'h00
`define DTC_RST_TIMER_MODE_SELECT    8'h00
`define DTC_RST_COUNT                8'h00
`define DTC_RST_TIMER_CLOCK_CONTROL  8'h01

// ==========================================================================
// Field positions
// ==========================================================================
`define DTC_CFG_OVERFLOW_FLAG_ONE    7
`define DTC_CFG_RUN_BIT_ONE          6
`define DTC_CFG_OVERFLOW_FLAG_ZERO   5
`define DTC_CFG_RUN_BIT_ZERO         4
`define DTC_CFG_EXT_IRQ_FLAG_ONE     3
`define DTC_CFG_EXT_IRQ_SENSE_ONE    2
`define DTC_CFG_EXT_IRQ_FLAG_ZERO    1
`define DTC_CFG_EXT_IRQ_SENSE_ZERO   0
`define DTC_MOD_GATE_CONTROL_ONE     7
`define DTC_MOD_SOURCE_SELECT_ONE    6
`define DTC_MOD_MODE_FIELD_ONE_HI    5
`define DTC_MOD_MODE_FIELD_ONE_LO    4
`define DTC_MOD_GATE_CONTROL_ZERO    3
`define DTC_MOD_SOURCE_SELECT_ZERO   2
`define DTC_MOD_MODE_FIELD_ZERO_HI   1
`define DTC_MOD_MODE_FIELD_ZERO_LO   0
`define DTC_CKC_WATCHDOG_SEL_HI      7
`define DTC_CKC_WATCHDOG_SEL_LO      6
`define DTC_CKC_CLOCK_DIV_SEL_ONE    4
`define DTC_CKC_CLOCK_DIV_SEL_ZERO   3

// ==========================================================================
// Counts
// ==========================================================================
`define DTC_DIV_SLOW                 12
`define DTC_DIV_FAST                 4
`define DTC_PRESCALE_MASK            8'h1F
`define DTC_WDT_CLOCKS_00            131072
`define DTC_WDT_CLOCKS_01            1048576
`define DTC_WDT_CLOCKS_10            8388608
`define DTC_WDT_CLOCKS_11            67108864

`endif

/* File: shared/dtc_pkg.sv */
// Types shared by the dual timer/counter pair and its bench.
// Assumes dtc_cfg.svh is on the include path.
package dtc_pkg;
   `include "dtc_cfg.svh"

   // =======================================================================
   // Operating modes of a timer
   // =======================================================================
   typedef enum logic [1:0] {
      DTC_MODE_PRESCALED = 2'h0,
      DTC_MODE_FULL16    = 2'h1,
      DTC_MODE_RELOAD8   = 2'h2,
      DTC_MODE_SPLIT     = 2'h3
   } dtc_mode_type;

   // =======================================================================
   // Pin and result bundles
   // =======================================================================
   typedef struct packed {
      logic count_pin_one;
      logic count_pin_zero;
      logic gate_pin_one;
      logic gate_pin_zero;
   } dtc_pins_type;

   typedef struct packed {
      logic overflow_flag_one;
      logic overflow_flag_zero;
   } dtc_irq_type;

   typedef struct packed {
      logic [7:0] lo;
      logic [7:0] hi;
      logic       ovf;
   } dtc_count_type;

   // =======================================================================
   // Whole state of the block
   // =======================================================================
   typedef struct packed {
      logic [7:0]  timer_configuration;
      logic [7:0]  timer_mode_select;
      logic [7:0]  count_low_zero;
      logic [7:0]  count_low_one;
      logic [7:0]  count_high_zero;
      logic [7:0]  count_high_one;
      logic [7:0]  timer_clock_control;
      logic [3:0]  div;
      logic [1:0]  pin_s1;
      logic [1:0]  pin_s2;
      logic [31:0] prdata;
   } dtc_state_type;
endpackage : dtc_pkg

/* File: rtl/dtc_timer_pair.sv */
// Dual up-counting timer/counter pair with an APB register slave.
// Assumes pins arrive synchronous to sys_clk and an APB master on sys_clk.
`timescale 1ns/1ps
`include "dtc_cfg.svh"

module dtc_timer_pair
   import dtc_pkg::*;
#(
   parameter int ADDR_W        = 12,
   parameter int PRESCALE_SLOW = `DTC_DIV_SLOW,
   parameter int PRESCALE_FAST = `DTC_DIV_FAST
)
(
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]   pwdata,
   input  wire logic [3:0]    pstrb,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire dtc_pins_type  pins,
   output dtc_irq_type        irq
);

   // ========================================================================
   // Elaboration checks
   // ========================================================================
   // The divider is four bits and the fast tick is taken from it.
   if (ADDR_W < 10 || ADDR_W > 32)
   begin : g_bad_addr
      $error("ADDR_W must lie between 10 and 32");
   end
   if (PRESCALE_SLOW < 2 || PRESCALE_SLOW > 16 || PRESCALE_FAST < 1 ||
       (PRESCALE_SLOW % PRESCALE_FAST) != 0)
   begin : g_bad_div
      $error("PRESCALE_SLOW must be 2..16 and a multiple of PRESCALE_FAST");
   end

   // ========================================================================
   // Counting step for one timer in modes 0, 1 and 2
   // ========================================================================
   function automatic dtc_count_type dtc_step
   (
      input dtc_mode_type m,
      input logic [7:0]   lo,
      input logic [7:0]   hi,
      input logic         inc
   );
      dtc_count_type r;
      r.lo  = lo;
      r.hi  = hi;
      r.ovf = 1'b0;
      if (inc)
      begin
         unique case (m)
            DTC_MODE_PRESCALED:
            begin
               // Upper three low bits are left alone; software ignores them.
               r.lo[4:0] = lo[4:0] + 5'h01;
               if (lo[4:0] == 5'h1F)
               begin
                  r.hi = hi + 8'h01;
                  r.ovf = (hi == 8'hFF);
               end
            end
            DTC_MODE_FULL16:
            begin
               {r.hi, r.lo} = {hi, lo} + 16'h0001;
               r.ovf = ({hi, lo} == 16'hFFFF);
            end
            DTC_MODE_RELOAD8:
            begin
               r.lo  = (lo == 8'hFF) ? hi : lo + 8'h01;
               r.ovf = (lo == 8'hFF);
            end
            DTC_MODE_SPLIT:
            begin
               // The caller owns mode 3, since it spans both timers.
               r.lo = lo;
            end
         endcase
      end
      return r;
   endfunction : dtc_step

   // ========================================================================
   // State
   // ========================================================================
   dtc_state_type st_r;
   dtc_state_type st_nxt;

   logic                tick_slow;
   logic                tick_fast;
   logic [1:0]          fall;
   logic                run0;
   logic                run1;
   logic                inc0;
   logic                inc1;
   logic                inc_split_hi;
   dtc_mode_type        mode0;
   dtc_mode_type        mode1;
   dtc_count_type       c0;
   dtc_count_type       c1;
   logic                ovf0;
   logic                ovf1;
   logic [ADDR_W-3:0]   word;
   logic                hit;
   logic                setup;
   logic                wr;
   logic [7:0]          rbyte;
   logic [7:0]          wbyte;

   // ========================================================================
   // APB decode
   // ========================================================================
   // Zero wait states: the access phase always completes at once, so the
   // read byte is latched during the setup cycle and held stable.
   assign word    = paddr[ADDR_W-1:2];
   assign setup   = psel & ~penable;
   assign pready  = psel & penable;
   assign pslverr = psel & penable & ~hit;
   assign wr      = psel & penable & pwrite & hit & pstrb[0];
   assign wbyte   = pwdata[7:0];
   assign prdata  = st_r.prdata;
   assign irq     = '{overflow_flag_one:
                      st_r.timer_configuration[`DTC_CFG_OVERFLOW_FLAG_ONE],
                      overflow_flag_zero:
                      st_r.timer_configuration[`DTC_CFG_OVERFLOW_FLAG_ZERO]};

   // A misaligned address is refused like an unmapped one, so a lane
   // offset can never alias a neighbouring register.
   // Address match and read mux; unmapped words read as zero.
   always_comb
   begin
      hit   = (paddr[1:0] == 2'h0);
      rbyte = 8'h00;
      unique case (word)
         (ADDR_W-2)'(`DTC_IDX_TIMER_CONFIGURATION):
            rbyte = st_r.timer_configuration;
         (ADDR_W-2)'(`DTC_IDX_TIMER_MODE_SELECT):
            rbyte = st_r.timer_mode_select;
         (ADDR_W-2)'(`DTC_IDX_COUNT_LOW_ZERO):
            rbyte = st_r.count_low_zero;
         (ADDR_W-2)'(`DTC_IDX_COUNT_LOW_ONE):
            rbyte = st_r.count_low_one;
         (ADDR_W-2)'(`DTC_IDX_COUNT_HIGH_ZERO):
            rbyte = st_r.count_high_zero;
         (ADDR_W-2)'(`DTC_IDX_COUNT_HIGH_ONE):
            rbyte = st_r.count_high_one;
         (ADDR_W-2)'(`DTC_IDX_TIMER_CLOCK_CONTROL):
            rbyte = st_r.timer_clock_control;
         default:
            hit = 1'b0;
      endcase
   end

   // ========================================================================
   // Count enables
   // ========================================================================
   // mode field select
   assign mode0 = dtc_mode_type'(st_r.timer_mode_select
                  [`DTC_MOD_MODE_FIELD_ZERO_HI:`DTC_MOD_MODE_FIELD_ZERO_LO]);
   assign mode1 = dtc_mode_type'(st_r.timer_mode_select
                  [`DTC_MOD_MODE_FIELD_ONE_HI:`DTC_MOD_MODE_FIELD_ONE_LO]);

   // One shared divider serves both rates, since the slow period is a
   // whole multiple of the fast one.
   // internal rate ticks
   assign tick_slow = (st_r.div == 4'(PRESCALE_SLOW - 1));
   assign tick_fast = (4'(st_r.div % 4'(PRESCALE_FAST)) ==
                       4'(PRESCALE_FAST - 1));

   assign fall = st_r.pin_s2 & ~st_r.pin_s1;

   // Gate pins are used as they arrive, with no extra stage, so a gate
   // that opens one cycle before a tick still lets that tick through.
   // gate and run
   assign run0 = st_r.timer_configuration[`DTC_CFG_RUN_BIT_ZERO] &
                 (~st_r.timer_mode_select[`DTC_MOD_GATE_CONTROL_ZERO] |
                  pins.gate_pin_zero);
   assign run1 = st_r.timer_configuration[`DTC_CFG_RUN_BIT_ONE] &
                 (~st_r.timer_mode_select[`DTC_MOD_GATE_CONTROL_ONE] |
                  pins.gate_pin_one);

   assign inc0 = run0 &
      (st_r.timer_mode_select[`DTC_MOD_SOURCE_SELECT_ZERO] ? fall[0] :
       (st_r.timer_clock_control[`DTC_CKC_CLOCK_DIV_SEL_ZERO] ?
        tick_fast : tick_slow));
   assign inc1 = run1 & (mode1 != DTC_MODE_SPLIT) &
      (st_r.timer_mode_select[`DTC_MOD_SOURCE_SELECT_ONE] ? fall[1] :
       (st_r.timer_clock_control[`DTC_CKC_CLOCK_DIV_SEL_ONE] ?
        tick_fast : tick_slow));
   // The split high byte is a pure timer: no gate and no pin, only the
   // run bit of timer one and the internal rate of timer zero.
   assign inc_split_hi = st_r.timer_configuration[`DTC_CFG_RUN_BIT_ONE] &
      (st_r.timer_clock_control[`DTC_CKC_CLOCK_DIV_SEL_ZERO] ?
       tick_fast : tick_slow);

   // ========================================================================
   // Counter arithmetic
   // ========================================================================
   // Split mode is patched in here and not in the step function, since
   // its high byte borrows the run bit and the flag of timer one.
   // upward counting
   always_comb
   begin
      c0 = dtc_step(mode0, st_r.count_low_zero, st_r.count_high_zero, inc0);
      c1 = dtc_step(mode1, st_r.count_low_one, st_r.count_high_one, inc1);
      ovf0 = c0.ovf;
      ovf1 = c1.ovf;
      if (mode0 == DTC_MODE_SPLIT)
      begin
         c0.lo = st_r.count_low_zero + 8'(inc0);
         ovf0  = inc0 & (st_r.count_low_zero == 8'hFF);
         c0.hi = st_r.count_high_zero + 8'(inc_split_hi);
         // Timer one loses its flag to the split high byte here.
         ovf1  = inc_split_hi & (st_r.count_high_zero == 8'hFF);
      end
   end

   // ========================================================================
   // Next state
   // ========================================================================
   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.div    = tick_slow ? 4'h0 : st_r.div + 4'h1;
      st_nxt.pin_s1 = {pins.count_pin_one, pins.count_pin_zero};
      st_nxt.pin_s2 = st_r.pin_s1;
      st_nxt.count_low_zero  = c0.lo;
      st_nxt.count_high_zero = c0.hi;
      st_nxt.count_low_one   = c1.lo;
      st_nxt.count_high_one  = c1.hi;
      if (setup)
      begin
         st_nxt.prdata = {24'h000000, rbyte};
      end
      // Software writes win over a count step in the same cycle.
      if (wr)
      begin
         unique case (word)
            (ADDR_W-2)'(`DTC_IDX_TIMER_CONFIGURATION):
               st_nxt.timer_configuration = wbyte;
            (ADDR_W-2)'(`DTC_IDX_TIMER_MODE_SELECT):
               st_nxt.timer_mode_select = wbyte;
            (ADDR_W-2)'(`DTC_IDX_COUNT_LOW_ZERO):
               st_nxt.count_low_zero = wbyte;
            (ADDR_W-2)'(`DTC_IDX_COUNT_LOW_ONE):
               st_nxt.count_low_one = wbyte;
            (ADDR_W-2)'(`DTC_IDX_COUNT_HIGH_ZERO):
               st_nxt.count_high_zero = wbyte;
            (ADDR_W-2)'(`DTC_IDX_COUNT_HIGH_ONE):
               st_nxt.count_high_one = wbyte;
            (ADDR_W-2)'(`DTC_IDX_TIMER_CLOCK_CONTROL):
               st_nxt.timer_clock_control = wbyte;
            default:
               st_nxt.div = st_nxt.div;
         endcase
      end
      // The flags are applied last, so a rollover in the cycle of a
      // software clear is never lost.
      // set beats clear
      if (ovf0)
      begin
         st_nxt.timer_configuration[`DTC_CFG_OVERFLOW_FLAG_ZERO] = 1'b1;
      end
      if (ovf1)
      begin
         st_nxt.timer_configuration[`DTC_CFG_OVERFLOW_FLAG_ONE] = 1'b1;
      end
   end

   // ========================================================================
   // State register
   // ========================================================================
   // Pin samplers reset high, the idle level, so no false fall follows.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_r <= '{timer_configuration: `DTC_RST_TIMER_CONFIGURATION,
                   timer_mode_select:   `DTC_RST_TIMER_MODE_SELECT,
                   count_low_zero:      `DTC_RST_COUNT,
                   count_low_one:       `DTC_RST_COUNT,
                   count_high_zero:     `DTC_RST_COUNT,
                   count_high_one:      `DTC_RST_COUNT,
                   timer_clock_control: `DTC_RST_TIMER_CLOCK_CONTROL,
                   div:                 4'h0,
                   pin_s1:              2'h3,
                   pin_s2:              2'h3,
                   prdata:              32'h00000000};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

endmodule : dtc_timer_pair

/* File: bench/dtc_monitor.sv */
// Checker for the timer pair: APB answers, read-back and flag outputs.
// Assumes it is bound to dtc_timer_pair and sees only its ports.
`timescale 1ns/1ps
module dtc_monitor
   import dtc_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input wire logic              sys_clk,
   input wire logic              rst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire dtc_pins_type      pins,
   input wire dtc_irq_type       irq
);
   logic       acc;
   logic       mapped;
   logic       wr_ok;
   logic [7:0] mode_sh;
   logic [7:0] ckc_sh;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ======================================================================
   // Helper logic
   // ======================================================================
   // Access decode; a write counts only with the low lane strobe.
   assign acc    = psel && penable;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr >= 12'h220)
                   && (paddr <= 12'h238);
   assign wr_ok  = acc && pwrite && pstrb[0];
   // Shadows of two plain registers, to judge what a read returns.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         mode_sh <= 8'h00;
         ckc_sh  <= 8'h01;
      end
      else if (wr_ok && paddr == 12'h224)
         mode_sh <= pwdata[7:0];
      else if (wr_ok && paddr == 12'h238)
         ckc_sh <= pwdata[7:0];
   end
   // ======================================================================
   // Sequences and assertions
   // ======================================================================
   sequence s_set_one;
      wr_ok && paddr == 12'h220 && pwdata[7];
   endsequence
   sequence s_cfg_write;
      wr_ok && paddr == 12'h220;
   endsequence
   a_ready_zero_wait: assert property (pready == acc)
      else $error("pready not equal to access phase");
   a_slverr_bad: assert property (acc && !mapped |-> pslverr)
      else $error("unmapped access not refused");
   a_slverr_good: assert property (acc && mapped |-> !pslverr)
      else $error("mapped access refused");
   a_read_upper: assert property (
      acc && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_flag_write: assert property (s_set_one |=> irq.overflow_flag_one)
      else $error("flag one write did not take effect");
   a_flag_fall: assert property (
      $fell(irq.overflow_flag_zero) |->
      $past(acc && pwrite && paddr == 12'h220))
      else $error("flag zero cleared without a write");
   a_mode_readback: assert property (
      acc && !pwrite && paddr == 12'h224 |-> prdata[7:0] == mode_sh)
      else $error("mode register read mismatch");
   a_ckc_readback: assert property (
      acc && !pwrite && paddr == 12'h238 |-> prdata[7:0] == ckc_sh)
      else $error("clock control read mismatch");
   // A software clear is legal, so only a written one must stick.
   a_cfg_hold: assert property (
      s_cfg_write ##0 pwdata[5] |=> irq.overflow_flag_zero)
      else $error("flag zero write did not take effect");
endmodule : dtc_monitor

bind dtc_timer_pair dtc_monitor #(.ADDR_W(ADDR_W)) u_mon (
   .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
   .irq(irq));

/* File: bench/dtc_pin_model.sv */
// Model of the external count and gate pins of the timer pair.
// Assumes the bench asks for falls one clock at a time.
`timescale 1ns/1ps
module dtc_pin_model
   import dtc_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic [1:0] fall_req,
   input wire logic [1:0] gate_lvl,
   output dtc_pins_type   pins
);
   logic [1:0] low0_r;
   logic [1:0] low1_r;
   // clean falls: each request holds a pin low for three clocks.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         low0_r <= 2'h0;
         low1_r <= 2'h0;
      end
      else
      begin
         low0_r <= fall_req[0] ? 2'h3 : low0_r - 2'(low0_r != 2'h0);
         low1_r <= fall_req[1] ? 2'h3 : low1_r - 2'(low1_r != 2'h0);
      end
   end
   // gate levels: gates follow the bench, count pins idle high.
   assign pins = '{count_pin_one:  (low1_r == 2'h0),
                   count_pin_zero: (low0_r == 2'h0),
                   gate_pin_one:   gate_lvl[1],
                   gate_pin_zero:  gate_lvl[0]};
endmodule : dtc_pin_model

/* File: bench/testbench.sv */
// Self-checking bench of the timer pair over APB with a pin model.
// Assumes the design package, header and pin model are compiled first.
`timescale 1ns/1ps
`include "dtc_cfg.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
   err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); \
   end end
module testbench;
   import dtc_pkg::*;
   localparam logic [7:0] cfg = `DTC_IDX_TIMER_CONFIGURATION;
   localparam logic [7:0] mdr = `DTC_IDX_TIMER_MODE_SELECT;
   localparam logic [7:0] lo0 = `DTC_IDX_COUNT_LOW_ZERO;
   localparam logic [7:0] lo1 = `DTC_IDX_COUNT_LOW_ONE;
   localparam logic [7:0] hi0 = `DTC_IDX_COUNT_HIGH_ZERO;
   localparam logic [7:0] hi1 = `DTC_IDX_COUNT_HIGH_ONE;
   localparam logic [7:0] ckc = `DTC_IDX_TIMER_CLOCK_CONTROL;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [1:0] fall_req = 2'h0;
   logic [1:0] gate_lvl = 2'h0;
   dtc_pins_type pins;
   dtc_irq_type irq;
   logic [7:0] rd;
   logic er;
   int err_total = 0;
   int num_checks = 0;
   dtc_timer_pair uut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pins(pins), .irq(irq));
   dtc_pin_model u_pins (.sys_clk(sys_clk), .rst(rst), .fall_req(fall_req),
      .gate_lvl(gate_lvl), .pins(pins));
   // Free running 50 MHz clock.
   always #10 sys_clk = ~sys_clk;
   // One APB transfer; request held until pready is seen at an edge.
   task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
            input logic [3:0] st);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      pstrb <= st;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Waits as long as the slave needs; only the watchdog ends a hang.
      do
         @(posedge sys_clk);
      while (pready !== 1'b1);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 4'hF);
   endtask : wr
   task rdchk(input logic [7:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00, 4'h0);
      `CHK(rd, e)
   endtask : rdchk
   task inrange(input logic [7:0] idx, input logic [7:0] l,
                input logic [7:0] h);
      apb(1'b0, idx, 8'h00, 4'h0);
      `CHK((rd >= l) && (rd <= h), 1'b1)
   endtask : inrange
   // Waits a bounded time for an overflow flag, then stops both timers.
   task wait_irq(input int b);
      for (int i = 0; i < 60; i++)
      begin
         @(posedge sys_clk);
         if (irq[b] === 1'b1) break;
      end
      `CHK(irq[b], 1'b1)
      wr(cfg, 8'h00);
   endtask : wait_irq
   task falls(input int p, input int n);
      repeat (n)
      begin
         @(posedge sys_clk);
         fall_req[p] <= 1'b1;
         @(posedge sys_clk);
         fall_req[p] <= 1'b0;
         repeat (6) @(posedge sys_clk);
      end
   endtask : falls
   // Reset values and an unmapped place.
   task t_reset;
      rdchk(cfg, 8'h00);
      rdchk(mdr, 8'h00);
      for (int i = 0; i < 4; i++) rdchk(8'(lo0 + i), 8'h00);
      rdchk(ckc, 8'h01);
      apb(1'b0, 8'h8F, 8'h00, 4'h0);
      `CHK({er, rd}, 9'h100)
      $display("test reset done");
   endtask : t_reset
   // Plain read-write, a write without strobe, stored bits.
   task t_rw;
      wr(hi1, 8'hA5);
      apb(1'b1, hi1, 8'h3C, 4'h0);
      rdchk(hi1, 8'hA5);
      wr(cfg, 8'hAF);
      rdchk(cfg, 8'hAF);
      `CHK(irq, 2'h3)
      wr(ckc, 8'hC1);
      rdchk(ckc, 8'hC1);
      wr(cfg, 8'h00);
      $display("test rw done");
   endtask : t_rw
   // Internal rates: both timers run 121 clocks, dividers swapped.
   task t_rate(input logic [7:0] ck, input logic [7:0] l0,
               input logic [7:0] l1);
      wr(mdr, 8'h11);
      wr(ckc, ck);
      for (int i = 0; i < 4; i++) wr(8'(lo0 + i), 8'h00);
      wr(cfg, 8'h50);
      repeat (118) @(posedge sys_clk);
      wr(cfg, 8'h00);
      inrange(lo0, l0 - 8'h1, l0 + 8'h1);
      inrange(lo1, l1 - 8'h1, l1 + 8'h1);
      $display("test rate done");
   endtask : t_rate
   // Rollover in modes 1, 0 and 2 at the slow rate.
   task t_ovf;
      wr(ckc, 8'h01);
      wr(mdr, 8'h01);
      wr(hi0, 8'hFF);
      wr(lo0, 8'hFE);
      wr(cfg, 8'h10);
      wait_irq(0);
      @(negedge sys_clk);
      `CHK(irq.overflow_flag_zero, 1'b0)
      rdchk(hi0, 8'h00);
      wr(mdr, 8'h00);
      wr(hi0, 8'hFF);
      wr(lo0, 8'h1F);
      wr(cfg, 8'h10);
      wait_irq(0);
      rdchk(hi0, 8'h00);
      apb(1'b0, lo0, 8'h00, 4'h0);
      `CHK(rd[4:0], 5'h00)
      wr(mdr, 8'h20);
      wr(hi1, 8'hF0);
      wr(lo1, 8'hFE);
      wr(cfg, 8'h40);
      wait_irq(1);
      rdchk(hi1, 8'hF0);
      rdchk(lo1, 8'hF0);
      $display("test overflow done");
   endtask : t_ovf
   // Pin counting, then gating by the gate pin.
   task t_cnt;
      wr(mdr, 8'h05);
      wr(lo0, 8'h00);
      wr(cfg, 8'h10);
      falls(0, 5);
      rdchk(lo0, 8'h05);
      wr(mdr, 8'h0D);
      falls(0, 3);
      rdchk(lo0, 8'h05);
      gate_lvl[0] <= 1'b1;
      falls(0, 3);
      rdchk(lo0, 8'h08);
      wr(mdr, 8'hC0);
      wr(lo1, 8'h00);
      gate_lvl[1] <= 1'b1;
      wr(cfg, 8'h40);
      falls(1, 2);
      rdchk(lo1, 8'h02);
      wr(cfg, 8'h00);
      $display("test count done");
   endtask : t_cnt
   // Split mode: high byte under run bit one, timer one holds.
   task t_split;
      wr(mdr, 8'h33);
      wr(ckc, 8'h09);
      wr(lo0, 8'h00);
      wr(hi0, 8'hFE);
      wr(lo1, 8'h55);
      wr(cfg, 8'h40);
      wait_irq(1);
      rdchk(lo0, 8'h00);
      rdchk(lo1, 8'h55);
      $display("test split done");
   endtask : t_split
   // Prints counts and the verdict, then ends the run.
   task stop_test;
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // Watchdog well beyond the several hundred clocks the tests need.
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      stop_test;
   end
   // Main sequence.
   initial
   begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset;
      t_rw;
      t_rate(8'h09, 8'h1E, 8'h0A);
      t_rate(8'h11, 8'h0A, 8'h1E);
      t_ovf;
      t_cnt;
      t_split;
      stop_test;
   end
endmodule : testbench
